// [rlf_master_failover_controller.sv]
// Master failover controller for a redundant link pair
`timescale 1ns/1ps
module rlf_master_failover_controller (
    // Clock and reset
    input  wire logic                           sys_clk_i,
    input  wire logic                           rst_n_i,
    // Configuration: remote port is a responder
    input  wire logic                           pri_responder_i,
    input  wire logic                           sec_responder_i,
    // Primary port fault inputs (asynchronous)
    input  wire logic                           pri_rx_link_loss_i,
    input  wire logic                           pri_partition_i,
    input  wire logic                           pri_excess_coll_i,
    input  wire logic                           pri_long_coll_i,
    input  wire logic                           pri_jabber_i,
    input  wire logic                           pri_xcvr_fail_i,
    input  wire logic                           pri_remote_fail_i,
    // Secondary port fault inputs (asynchronous)
    input  wire logic                           sec_rx_link_loss_i,
    input  wire logic                           sec_partition_i,
    input  wire logic                           sec_disabled_i,
    input  wire logic                           sec_excess_coll_i,
    input  wire logic                           sec_long_coll_i,
    input  wire logic                           sec_jabber_i,
    input  wire logic                           sec_xcvr_fail_i,
    input  wire logic                           sec_remote_fail_i,
    // Port enables
    output logic                                pri_enable_o,
    output logic                                sec_enable_o,
    // Management status
    output logic                                pri_ok_o,
    output logic                                sec_ok_o,
    output logic                                sec_active_o,
    output logic [rlf_pkg::CNT_WIDTH-1:0]       trans_count_o
);

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for all fault inputs
    localparam int NF = 16;
    wire  [NF-1:0] raw_w = {pri_rx_link_loss_i, pri_partition_i,
                            pri_excess_coll_i, pri_long_coll_i,
                            pri_jabber_i, pri_xcvr_fail_i,
                            pri_remote_fail_i, pri_responder_i,
                            sec_rx_link_loss_i, sec_partition_i,
                            sec_disabled_i, sec_excess_coll_i,
                            sec_long_coll_i, sec_jabber_i,
                            sec_xcvr_fail_i, sec_remote_fail_i};
    logic [NF-1:0] meta_r;
    logic [NF-1:0] sync_r;
    logic          sec_resp_meta_r;
    logic          sec_resp_r;

    always_ff @(posedge sys_clk_i) begin
        meta_r          <= raw_w;
        sync_r          <= meta_r;
        sec_resp_meta_r <= sec_responder_i;
        sec_resp_r      <= sec_resp_meta_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault decode
    wire pri_resp_w  = sync_r[8];
    // Far-end reports only mean something from a responder
    wire pri_far_w   = sync_r[9] & pri_resp_w;
    wire sec_far_w   = sync_r[0] & sec_resp_r;
    wire pri_fail_w  = sync_r[15] | sync_r[14]
                     | (|sync_r[13:10])
                     | pri_far_w;
    wire sec_fail_w  = sync_r[7] | sync_r[6] | sync_r[5] | (|sync_r[4:1])
                     | sec_far_w;

    ////////////////////////////////////////////////////////////////////////
    // Control state machine
    rlf_pkg::rlf_state_t state_r;
    rlf_pkg::rlf_state_t state_nxt;
    logic [15:0]         gap_r;
    logic                init_r;
    wire                 gap_done_w = (gap_r == 16'h0000);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // Wait for a clean primary before enabling it
            rlf_pkg::RLF_INIT:
                if (!init_r && !pri_fail_w) state_nxt = rlf_pkg::RLF_PRI_ACTIVE;
            rlf_pkg::RLF_PRI_ACTIVE:
                if (pri_fail_w) state_nxt = rlf_pkg::RLF_TO_SEC;
            rlf_pkg::RLF_TO_SEC:
                if (gap_done_w) state_nxt = rlf_pkg::RLF_SEC_ACTIVE;
            // Primary stays idle while the secondary is healthy
            rlf_pkg::RLF_SEC_ACTIVE:
                if (sec_fail_w) state_nxt = rlf_pkg::RLF_TO_PRI;
            rlf_pkg::RLF_TO_PRI:
                if (gap_done_w) state_nxt = pri_fail_w ? rlf_pkg::RLF_BOTH_DOWN
                                                       : rlf_pkg::RLF_PRI_ACTIVE;
            // Both failed: nothing enabled, take whichever heals first, primary if both heal in the same cycle
            rlf_pkg::RLF_BOTH_DOWN:
                if (!pri_fail_w) state_nxt = rlf_pkg::RLF_PRI_ACTIVE;
                else if (!sec_fail_w) state_nxt = rlf_pkg::RLF_SEC_ACTIVE;
            default: state_nxt = rlf_pkg::RLF_INIT;
        endcase
    end

    wire trans_w = (state_nxt != state_r) &&
                   ((state_nxt == rlf_pkg::RLF_PRI_ACTIVE) ||
                    (state_nxt == rlf_pkg::RLF_SEC_ACTIVE) ||
                    (state_nxt == rlf_pkg::RLF_TO_SEC) ||
                    (state_nxt == rlf_pkg::RLF_TO_PRI));
    wire entering_gap_w = (state_nxt != state_r) &&
                          ((state_nxt == rlf_pkg::RLF_TO_SEC) ||
                           (state_nxt == rlf_pkg::RLF_TO_PRI));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r <= rlf_pkg::RLF_INIT;
            init_r  <= 1'b1;
            gap_r   <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            // One cycle so the synchronisers fill before judging the link
            init_r  <= 1'b0;
            if (entering_gap_w)
                gap_r <= 16'(rlf_pkg::GAP_CYCLES - 1);
            else if (!gap_done_w)
                gap_r <= gap_r - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: at most one enable on at a time, fixed port identities
    logic [rlf_pkg::CNT_WIDTH-1:0] cnt_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pri_enable_o <= 1'b0;
            sec_enable_o <= 1'b0;
            pri_ok_o     <= 1'b0;
            sec_ok_o     <= 1'b0;
            sec_active_o <= 1'b0;
            cnt_r        <= rlf_pkg::CNT_RESET;
        end else begin
            pri_enable_o <= (state_nxt == rlf_pkg::RLF_PRI_ACTIVE);
            sec_enable_o <= (state_nxt == rlf_pkg::RLF_SEC_ACTIVE);
            pri_ok_o     <= !pri_fail_w;
            sec_ok_o     <= !sec_fail_w;
            sec_active_o <= (state_nxt == rlf_pkg::RLF_SEC_ACTIVE);
            if (trans_w)
                cnt_r <= cnt_r + 1'b1;
        end
    end
    assign trans_count_o = cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_never_both_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !(pri_enable_o && sec_enable_o))
        else $error("Both master links enabled");
    a_pri_off_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(sec_enable_o) |-> $past(!pri_enable_o))
        else $error("Secondary enabled before primary was off");
    a_fail_drops_pri: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_PRI_ACTIVE && pri_fail_w) |=> !pri_enable_o)
        else $error("Primary not disabled on failure");
    a_switch_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_PRI_ACTIVE && pri_fail_w && !sec_fail_w)
        |-> ##[1:45] sec_enable_o or (sec_fail_w))
        else $error("Switchover too slow");
    a_pri_held_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_SEC_ACTIVE && !sec_fail_w)
        |=> !pri_enable_o)
        else $error("Repaired primary re-enabled");
    a_init_clean: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_INIT && pri_fail_w) |=> !pri_enable_o)
        else $error("Faulty primary enabled at start");
    a_reset_standby: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> !sec_enable_o && state_r == rlf_pkg::RLF_INIT)
        else $error("Secondary not in standby after reset");
    a_count_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        trans_w |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("Transition not counted");
    // Checks the port, not the decode, so a broken mask would show here
    a_far_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_PRI_ACTIVE && !pri_resp_w
         && !(sync_r[15] | sync_r[14] | (|sync_r[13:10])))
        |=> pri_enable_o)
        else $error("Nonresponder report honoured");
    a_sec_fail_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == rlf_pkg::RLF_SEC_ACTIVE && sec_fail_w)
        |=> !sec_enable_o)
        else $error("Failed secondary left enabled");
    a_active_status: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sec_active_o == sec_enable_o)
        else $error("Active status disagrees with enable");
    a_pri_ok_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rst_n_i |=> (pri_ok_o == !$past(pri_fail_w)))
        else $error("Primary status stale");
    a_sec_ok_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rst_n_i |=> (sec_ok_o == !$past(sec_fail_w)))
        else $error("Secondary status stale");

endmodule // rlf_master_failover_controller

// [rlf_pkg.sv]
// Package for the redundant link failover controller
package rlf_pkg;
    // Gap between disabling one port and enabling the other, in ns
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned GAP_TIME_NS   = 1000;
    localparam int unsigned GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    // Longest allowed switchover, in ms, and its cycle budget
    localparam int unsigned SWITCH_MAX_MS = 10;
    localparam int unsigned SWITCH_MAX_CYCLES = SWITCH_MAX_MS * 1000000
                                                / CLK_PERIOD_NS;
    localparam int unsigned CNT_WIDTH     = 16;
    localparam logic [15:0] CNT_RESET     = 16'h0000;

    typedef enum logic [2:0] {
        RLF_INIT,
        RLF_PRI_ACTIVE,
        RLF_TO_SEC,
        RLF_SEC_ACTIVE,
        RLF_TO_PRI,
        RLF_BOTH_DOWN
    } rlf_state_t;
endpackage

// [rlf_remote_port_model.sv]
// Model of the remote responder port on either link
`timescale 1ns/1ps
module rlf_remote_port_model #(
    parameter bit RESPONDER = 1'b1
) (
    // Far-end receive link state, set by the bench
    input  wire logic rx_cut_i,
    // Report to the master and own port enable
    output logic      remote_fail_o,
    output logic      port_enable_o
);
    // A responder reports its own receive loss to the master
    assign remote_fail_o = RESPONDER & rx_cut_i;
    // Remote ports never switch; only the master picks the link
    assign port_enable_o = 1'b1;
endmodule // rlf_remote_port_model

// [tb_top.sv]
// Testbench for the redundant link failover controller
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        pri_resp  = 1'b1;
    logic        rx_cut    = 1'b0;
    logic [5:0]  pri_f     = 6'h00;
    logic [6:0]  sec_f     = 7'h00;
    logic        pri_rf, pri_en, sec_en, pri_ok, sec_ok;
    logic        sec_cut   = 1'b0;
    logic        sec_rf, sec_act;
    logic [15:0] cnt;
    logic [15:0] exp_cnt;
    int          n_errors  = 0;
    int          tests_run = 0;
    localparam int GB = rlf_pkg::GAP_CYCLES + 10;
    always #12.5 sys_clk_i = ~sys_clk_i;
    rlf_remote_port_model rlf_remote_port_model_i (.rx_cut_i(rx_cut),
        .remote_fail_o(pri_rf), .port_enable_o());
    rlf_remote_port_model rlf_remote_port_model_s_i (.rx_cut_i(sec_cut),
        .remote_fail_o(sec_rf), .port_enable_o());
    rlf_master_failover_controller rlf_master_failover_controller_i (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .pri_responder_i(pri_resp), .sec_responder_i(1'b1),
        .pri_rx_link_loss_i(pri_f[0]), .pri_partition_i(pri_f[1]),
        .pri_excess_coll_i(pri_f[2]), .pri_long_coll_i(pri_f[3]),
        .pri_jabber_i(pri_f[4]), .pri_xcvr_fail_i(pri_f[5]),
        .pri_remote_fail_i(pri_rf), .sec_rx_link_loss_i(sec_f[0]),
        .sec_partition_i(sec_f[1]), .sec_disabled_i(sec_f[2]),
        .sec_excess_coll_i(sec_f[3]), .sec_long_coll_i(sec_f[4]),
        .sec_jabber_i(sec_f[5]), .sec_xcvr_fail_i(sec_f[6]),
        .sec_remote_fail_i(sec_rf), .pri_enable_o(pri_en),
        .sec_enable_o(sec_en), .pri_ok_o(pri_ok), .sec_ok_o(sec_ok),
        .sec_active_o(sec_act), .trans_count_o(cnt));
    ////////////////////////////////////////
    task automatic conclude();
        $display("Errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for one enable to reach a level
    task automatic wait_en(input bit sec, input logic val, input int bound);
        int k;
        k = 0;
        while (((sec ? sec_en : pri_en) !== val) && k < bound) begin
            @(negedge sys_clk_i);
            k++;
        end
        if (k >= bound) begin
            n_errors++;
            $display("ERROR %0t: enable wait timed out", $time);
            conclude();
        end
    endtask
    ////////////////////////////////////////
    // Primary partitioned through reset must stay off until clean
    task automatic sc_startup();
        pri_f = 6'h02;
        repeat (6) @(negedge sys_clk_i);
        check({pri_en, sec_en, pri_ok, sec_ok}, 16'h0000);
        check(cnt, 16'h0000);
        rst_n_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        check({pri_en, pri_ok}, 16'h0000);
        pri_f = 6'h00;
        wait_en(1'b0, 1'b1, 10);
        check(sec_en, 16'h0000);
        exp_cnt = 16'h0001;
        check(cnt, exp_cnt);
    endtask
    // One primary cause, repair, then one secondary cause
    task automatic sc_failover(input int k);
        if (k < 6)
            pri_f = 6'h01 << k;
        else
            rx_cut = 1'b1;
        wait_en(1'b0, 1'b0, 10);
        check(sec_en, 16'h0000);
        wait_en(1'b1, 1'b1, GB);
        check(pri_en, 16'h0000);
        check(sec_act, 16'h0001);
        pri_f = 6'h00;
        rx_cut = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        check({pri_en, sec_en, pri_ok}, 16'h0003);
        exp_cnt += 16'h0002;
        check(cnt, exp_cnt);
        if (k < 7)
            sec_f = 7'h01 << k;
        else
            sec_cut = 1'b1;
        wait_en(1'b1, 1'b0, 10);
        wait_en(1'b0, 1'b1, GB);
        check({sec_act, sec_ok}, 16'h0000);
        sec_f = 7'h00;
        sec_cut = 1'b0;
        exp_cnt += 16'h0002;
        repeat (5) @(negedge sys_clk_i);
        check({cnt[0], sec_ok}, {exp_cnt[0], 1'b1});
        check(cnt, exp_cnt);
    endtask
    // Far-end report from a port configured as nonresponder is ignored
    task automatic sc_nonresp();
        pri_resp = 1'b0;
        rx_cut = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        check({pri_en, sec_en}, 16'h0002);
        rx_cut = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        pri_resp = 1'b1;
    endtask
    initial begin
        sc_startup();
        for (int k = 0; k < 8; k++)
            sc_failover(k);
        sc_nonresp();
        conclude();
    end
endmodule // tb_top
